// ### inc/arc_pkg.sv
// Constants and types for the converter result coding and reset select block
// =====================================================================
// Overview of operation
// - Unipolar results are straight binary, zero input all zeros, midscale MSB only, full scale all ones.
// - Bipolar results are offset binary, negative full scale all zeros, zero input MSB only, positive full scale all ones.
// - The result word is 16 bits on the low-resolution variant and 24 bits on the high one.
// - One polarity bit in the configuration selects unipolar or bipolar coding.
// - Thirty-two consecutive ones on the serial input reset the interface state, the reset wait counter and the configuration register.
// - The same full reset happens automatically at power-up.
// - The burnout enable bit switches both 100 nA sources together, and zero turns both off.
// - Channel code all ones converts the analog supply divided by 6 against the internal reference.
// - Channel code 1,1,0 converts the temperature sensor against the internal reference.
// - After a reset the serial interface expects a write to the communication register.
package arc_pkg;
  // =====================================================================
  // Sizes and timing
  localparam int RES_BITS_LO = 16;
  localparam int RES_BITS_HI = 24;
  localparam int RESET_ONES = 32;
  localparam int CLK_MHZ = 125;
  localparam int WAIT_US = 500;
  localparam int WAIT_CYCLES = WAIT_US * CLK_MHZ;
  localparam int CH_BITS = 3;
  // =====================================================================
  // Configuration fields and reset values
  localparam logic [2:0] CH_SUPPLY = 3'h7;
  localparam logic [2:0] CH_TEMP = 3'h6;
  localparam logic [2:0] CH_RESET = 3'h0;
  localparam logic UNIPOLAR_RESET = 1'b0;
  localparam logic BURNOUT_RESET = 1'b0;

  typedef struct packed {
    logic unipolar;
    logic burnout_current_enable;
    logic [2:0] channel_select;
  } arc_cfg_t;

  typedef struct packed {
    logic supply_monitor;
    logic temp_sensor;
    logic internal_reference;
    logic external_reference_input;
    logic burnout_source;
    logic burnout_sink;
  } arc_route_t;

  typedef enum logic [1:0] {
    ARC_EXPECT_COMM = 2'b00,
    ARC_BUSY = 2'b01,
    ARC_ACTIVE = 2'b10
  } arc_if_state_t;

  localparam arc_cfg_t CFG_RESET = '{unipolar: UNIPOLAR_RESET, burnout_current_enable: BURNOUT_RESET,
                                    channel_select: CH_RESET};
endpackage : arc_pkg

// ### rtl/arc_coder.sv
// Result coder: signed code to straight or offset binary with saturation
`timescale 1ns/1ps
`default_nettype none
module arc_coder #(
  parameter int N = 24
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic unipolar,
  input wire logic [N+1:0] raw,
  output logic [N-1:0] code
);
  // Raw is signed, scaled so 2^N is full span; bipolar adds 2^(N-1)
  // One guard bit above the raw width so the bipolar offset cannot wrap a large positive code
  localparam logic signed [N+2:0] HALF = (N+3)'(1) <<< (N - 1);
  localparam logic signed [N+2:0] TOP = ((N+3)'(1) <<< N) - (N+3)'(1);
  wire logic signed [N+2:0] sraw = $signed({raw[N+1], raw});
  wire logic signed [N+2:0] shifted = unipolar ? sraw : sraw + HALF;
  wire logic low = shifted < 0;
  wire logic high = shifted > TOP;
  wire logic [N-1:0] next_code = low ? '0 : (high ? '1 : shifted[N-1:0]);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      code <= '0;
    end else begin
      code <= next_code;
    end
  end

  a_sat_high: assert property (@(posedge clk) disable iff (!rst_n)
    high |=> code == '1) else $error("High saturation missing");
  a_sat_low: assert property (@(posedge clk) disable iff (!rst_n)
    low |=> code == '0) else $error("Low saturation missing");
  a_bip_mid: assert property (@(posedge clk) disable iff (!rst_n)
    (!unipolar && sraw == 0) |=> code == {1'b1, {(N-1){1'b0}}}) else $error("Bipolar zero not midscale");
  a_uni_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (unipolar && sraw == 0) |=> code == '0) else $error("Unipolar zero not zero");
endmodule : arc_coder
`default_nettype wire

// ### rtl/arc_top.sv
// Top: config decode, serial ones-run reset, reset wait and result coding
`timescale 1ns/1ps
`default_nettype none
module arc_top #(
  parameter int N = arc_pkg::RES_BITS_HI,
  parameter int WAIT_CYCLES = arc_pkg::WAIT_CYCLES
) (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic SERIAL_DIN,
  input wire logic SCLK_RISE,
  input wire logic CFG_WRITE,
  input wire arc_pkg::arc_cfg_t CFG_IN,
  input wire logic COMM_DONE,
  input wire logic [N+1:0] RAW_RESULT,
  output logic [N-1:0] RESULT_CODE,
  output arc_pkg::arc_cfg_t CFG,
  output arc_pkg::arc_route_t ROUTE,
  output logic FULL_RESET,
  output logic RESET_BUSY,
  output logic EXPECT_COMM_WRITE
);
  // =====================================================================
  // Ones-run detector; counts serial clock rising edges with DIN high
  logic [5:0] ones;
  logic full_reset;
  logic [$clog2(WAIT_CYCLES+1)-1:0] wait_cnt;
  arc_pkg::arc_if_state_t state;
  arc_pkg::arc_cfg_t cfg;

  wire logic ones_hit = SCLK_RISE && SERIAL_DIN && (ones == 6'(arc_pkg::RESET_ONES - 1));
  wire logic [5:0] next_ones = !SCLK_RISE ? ones : (SERIAL_DIN ? (ones_hit ? 6'h00 : ones + 6'h01) : 6'h00);

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      ones <= 6'h00;
      full_reset <= 1'b1;
    end else begin
      ones <= next_ones;
      full_reset <= ones_hit;
    end
  end

  // =====================================================================
  // Interface state; a reset holds off access for the wait time
  // Host must honour the wait; access during it is simply ignored
  wire logic wait_done = wait_cnt == '0;
  wire logic cfg_ok = CFG_WRITE && state != arc_pkg::ARC_BUSY;

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N || full_reset) begin
      state <= arc_pkg::ARC_BUSY;
      wait_cnt <= ($clog2(WAIT_CYCLES+1))'(WAIT_CYCLES);
      cfg <= arc_pkg::CFG_RESET;
    end else begin
      if (!wait_done) begin
        wait_cnt <= wait_cnt - 1'b1;
      end
      unique case (state)
        arc_pkg::ARC_BUSY: begin
          if (wait_done) begin
            state <= arc_pkg::ARC_EXPECT_COMM;
          end
        end
        arc_pkg::ARC_EXPECT_COMM: begin
          if (COMM_DONE) begin
            state <= arc_pkg::ARC_ACTIVE;
          end
        end
        arc_pkg::ARC_ACTIVE: begin
          if (COMM_DONE) begin
            state <= arc_pkg::ARC_EXPECT_COMM;
          end
        end
        default: begin
          state <= arc_pkg::ARC_EXPECT_COMM;
        end
      endcase
      if (cfg_ok) begin
        cfg <= CFG_IN;
      end
    end
  end

  // =====================================================================
  // Analog routing decode
  wire logic sel_supply = cfg.channel_select == arc_pkg::CH_SUPPLY;
  wire logic sel_temp = cfg.channel_select == arc_pkg::CH_TEMP;
  assign ROUTE.supply_monitor = sel_supply;
  assign ROUTE.temp_sensor = sel_temp;
  assign ROUTE.internal_reference = sel_supply || sel_temp;
  assign ROUTE.external_reference_input = !(sel_supply || sel_temp);
  assign ROUTE.burnout_source = cfg.burnout_current_enable;
  assign ROUTE.burnout_sink = cfg.burnout_current_enable;

  assign CFG = cfg;
  assign FULL_RESET = full_reset;
  assign RESET_BUSY = state == arc_pkg::ARC_BUSY;
  assign EXPECT_COMM_WRITE = state == arc_pkg::ARC_EXPECT_COMM;

  // =====================================================================
  // Result coding, width fixed by variant
  arc_coder #(.N(N)) u_coder (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .unipolar(cfg.unipolar),
    .raw(RAW_RESULT),
    .code(RESULT_CODE)
  );

  a_ones_reset: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    ones_hit |=> FULL_RESET ##1 (CFG == arc_pkg::CFG_RESET && RESET_BUSY)) else $error("Ones run did not reset");
  a_burnout_pair: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    ROUTE.burnout_source == ROUTE.burnout_sink) else $error("Burnout sources split");
  a_supply_ref: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    CFG.channel_select == 3'h7 |-> ROUTE.supply_monitor && ROUTE.internal_reference) else $error("Supply route wrong");
  a_temp_ref: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    CFG.channel_select == 3'h6 |-> ROUTE.temp_sensor && !ROUTE.external_reference_input) else $error("Temp route wrong");
  a_after_wait: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (RESET_BUSY && wait_done && !FULL_RESET) |=> EXPECT_COMM_WRITE) else $error("No comm state after reset");
  a_busy_lock: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (RESET_BUSY && !FULL_RESET) |=> $stable(CFG)) else $error("Config changed during wait");
endmodule : arc_top
`default_nettype wire

// ### sim/arc_host_model.sv
// Host side serial model: data bits with one-cycle clock strobes
`timescale 1ns/1ps
`default_nettype none
module arc_host_model (
  input wire logic clk,
  input wire logic busy,
  output logic din,
  output logic sclk_rise
);
  initial begin
    din = 1'b0;
    sclk_rise = 1'b0;
  end
  // =====================================================================
  // Bit transfer
  task automatic send(input logic b, input int count);
    for (int i = 0; i < count; i++) begin
      @(negedge clk);
      din = b;
      sclk_rise = 1'b1;
      @(negedge clk);
      sclk_rise = 1'b0;
      // Released line shows the inverse, never a stale bit
      din = ~b;
    end
  endtask : send
  // Controller keeps off the registers until busy drops or 100 cycles have passed
  task automatic wait_idle();
    for (int i = 0; i < 100 && busy !== 1'b0; i++) @(negedge clk);
  endtask : wait_idle
endmodule : arc_host_model
`default_nettype wire

// ### sim/test_adc_result_coding_reset_select.sv
// Self-checking bench for the result coding and reset select block
`timescale 1ns/1ps
`default_nettype none
module test_adc_result_coding_reset_select;
  localparam int N = 16;
  logic clk, rst_n, din, srise, cfg_wr, comm_done, full_reset, busy, exp_comm;
  arc_pkg::arc_cfg_t cfg_in, cfg;
  arc_pkg::arc_route_t route;
  logic [N+1:0] raw;
  logic [N-1:0] code;
  logic [31:0] seed = 32'h9145;
  logic [31:0] r;
  int mismatches = 0, num_checks = 0, resets = 0;
  int corner [7] = '{0, 2**(N-1), 2**N-1, 2**N, -1, -(2**(N-1)), -(2**(N-1))-1};
  // Short reset wait keeps the run brief
  arc_top #(.N(N), .WAIT_CYCLES(8)) arc_top_inst (.CORE_CLK(clk), .RST_N(rst_n), .SERIAL_DIN(din),
    .SCLK_RISE(srise), .CFG_WRITE(cfg_wr), .CFG_IN(cfg_in), .COMM_DONE(comm_done), .RAW_RESULT(raw),
    .RESULT_CODE(code), .CFG(cfg), .ROUTE(route), .FULL_RESET(full_reset), .RESET_BUSY(busy),
    .EXPECT_COMM_WRITE(exp_comm));
  arc_host_model arc_host_model_inst (.clk(clk), .busy(busy), .din(din), .sclk_rise(srise));
  // =====================================================================
  // Expectations
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic [N-1:0] exp_code(input logic uni, input logic [N+1:0] v);
    logic signed [N+2:0] s;
    s = $signed({v[N+1], v}) + (uni ? 0 : 2**(N-1));
    if (s < 0) return '0;
    if (s > 2**N-1) return '1;
    return s[N-1:0];
  endfunction : exp_code
  function automatic arc_pkg::arc_route_t exp_route(input arc_pkg::arc_cfg_t c);
    logic intl;
    intl = c.channel_select[2] & c.channel_select[1];
    return {c.channel_select == 3'h7, c.channel_select == 3'h6, intl, !intl, {2{c.burnout_current_enable}}};
  endfunction : exp_route
  // =====================================================================
  // Checks and drivers
  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_val
  task automatic write_cfg(input arc_pkg::arc_cfg_t c);
    @(negedge clk);
    cfg_wr = 1'b1;
    cfg_in = c;
    @(negedge clk);
    cfg_wr = 1'b0;
  endtask : write_cfg
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) if (rst_n && $rose(full_reset)) resets++;
  initial begin
    #(8 * 2000);
    mismatches++;
    results();
  end
  // =====================================================================
  // Scenarios
  initial begin
    rst_n = 1'b0;
    cfg_wr = 1'b0;
    cfg_in = '0;
    comm_done = 1'b0;
    raw = '0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    arc_host_model_inst.wait_idle();
    chk_val("cfg", arc_pkg::CFG_RESET, cfg);
    chk_val("expect", 1, exp_comm);
    for (int i = 0; i < 8; i++) begin
      r = xs();
      write_cfg(arc_pkg::arc_cfg_t'({r[1:0], 3'(i)}));
      chk_val("cfg", {r[1:0], 3'(i)}, cfg);
      chk_val("route", exp_route(cfg_in), route);
    end
    for (int u = 0; u < 2; u++) begin
      write_cfg(arc_pkg::arc_cfg_t'({1'(u), 4'h0}));
      for (int j = 0; j < 20; j++) begin
        r = xs();
        @(negedge clk);
        raw = (j < 7) ? (N+2)'(corner[j]) : r[N+1:0];
        @(negedge clk);
        chk_val("code", exp_code(1'(u), raw), code);
      end
    end
    @(negedge clk);
    comm_done = 1'b1;
    @(negedge clk);
    comm_done = 1'b0;
    chk_val("expect", 0, exp_comm);
    write_cfg(5'h1f);
    arc_host_model_inst.send(1'b1, 31);
    arc_host_model_inst.send(1'b0, 1);
    arc_host_model_inst.send(1'b1, 31);
    chk_val("resets", 0, resets);
    arc_host_model_inst.send(1'b1, 1);
    repeat (2) @(negedge clk);
    chk_val("resets", 1, resets);
    chk_val("busy", 1, busy);
    write_cfg(5'h1f);
    chk_val("cfg", arc_pkg::CFG_RESET, cfg);
    arc_host_model_inst.wait_idle();
    chk_val("expect", 1, exp_comm);
    results();
  end
endmodule : test_adc_result_coding_reset_select
`default_nettype wire
